// >>> core/drcm_match.sv
// request tag comparator for one delayed entry
module drcm_match (
   // compared fields
   input  wire logic [drcm_pkg::TAG_W-1:0] req_tag,
   input  wire logic [drcm_pkg::TAG_W-1:0] held_tag,
   // result
   output logic                            hit
);
   // address, command and byte enables must all agree
   assign hit = (req_tag == held_tag);
endmodule

// >>> core/drcm_pkg.sv
// constants and types for the delayed read completion matcher
package drcm_pkg;
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   localparam int CMD_W  = 4;
   localparam int BE_W   = 4;
   localparam int TAG_W  = ADDR_W + CMD_W + BE_W;
   localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
   localparam logic [TAG_W-1:0]  TAG_RST  = 40'h00_0000_0000;

   // answer codes on the near side
   localparam logic [1:0] ANS_NONE  = 2'h0;
   localparam logic [1:0] ANS_RETRY = 2'h1;
   localparam logic [1:0] ANS_DATA  = 2'h2;

   // one entry state: free, fetch pending, completion held
   typedef enum logic [2:0] {
      DRCM_FREE  = 3'h1,
      DRCM_FETCH = 3'h2,
      DRCM_HELD  = 3'h4
   } drcm_state_t;
endpackage

// >>> core/drcm_top.sv
// delayed read completion matcher, target side of a bridge
// Overview of operation
// - a read claims the held entry only on equal address, command, enables.
// - a first read attempt is retried and queued as a delayed request.
// - fetched data is kept with its request until a matching read retries.
// - a memory write is posted while held and leaves the held data alone.
// - any master whose read matches gets the completion, not only its owner.
// - an I/O controller with delayed termination acts as this logic does.
module drcm_top (
   // clock and reset
   input  wire logic                          MCLK,
   input  wire logic                          RSTN,
   // near-side read request, one-cycle strobe
   input  wire logic                          RD_REQ,
   input  wire logic [drcm_pkg::ADDR_W-1:0]   RD_ADDR,
   input  wire logic [drcm_pkg::CMD_W-1:0]    RD_CMD,
   input  wire logic [drcm_pkg::BE_W-1:0]     RD_BE,
   // near-side posted write, one-cycle strobe
   input  wire logic                          WR_REQ,
   input  wire logic [drcm_pkg::ADDR_W-1:0]   WR_ADDR,
   input  wire logic [drcm_pkg::DATA_W-1:0]   WR_DATA,
   input  wire logic [drcm_pkg::BE_W-1:0]     WR_BE,
   // near-side answer
   output logic [1:0]                         RD_ANS,
   output logic [drcm_pkg::DATA_W-1:0]        RD_DATA,
   output logic                               WR_ACK,
   // far-side fetch request
   output logic                               FAR_RD_REQ,
   output logic [drcm_pkg::ADDR_W-1:0]        FAR_RD_ADDR,
   output logic [drcm_pkg::CMD_W-1:0]         FAR_RD_CMD,
   output logic [drcm_pkg::BE_W-1:0]          FAR_RD_BE,
   input  wire logic                          FAR_RD_DONE,
   input  wire logic [drcm_pkg::DATA_W-1:0]   FAR_RD_DATA,
   // far-side posted write
   output logic                               FAR_WR_REQ,
   output logic [drcm_pkg::ADDR_W-1:0]        FAR_WR_ADDR,
   output logic [drcm_pkg::DATA_W-1:0]        FAR_WR_DATA,
   output logic [drcm_pkg::BE_W-1:0]          FAR_WR_BE,
   // entry status
   output logic                               ENTRY_HELD
);
   drcm_pkg::drcm_state_t             state, next_state;
   logic [drcm_pkg::TAG_W-1:0]        tag, next_tag;
   logic [drcm_pkg::DATA_W-1:0]       data, next_data;
   logic [1:0]                        ans, next_ans;
   logic [drcm_pkg::DATA_W-1:0]       rdata, next_rdata;
   logic                              far_req, next_far_req;
   logic                              held, next_held;
   logic                              wreq, next_wreq;
   logic [drcm_pkg::ADDR_W-1:0]       waddr, next_waddr;
   logic [drcm_pkg::DATA_W-1:0]       wdata, next_wdata;
   logic [drcm_pkg::BE_W-1:0]         wbe, next_wbe;
   logic [drcm_pkg::TAG_W-1:0]        req_tag;
   logic                              hit;

   assign req_tag = {RD_ADDR, RD_CMD, RD_BE};

   // field comparison of request against queued entry
   drcm_match u_match (
      .req_tag  (req_tag),
      .held_tag (tag),
      .hit      (hit)
   );

   // delayed entry and answer next values
   always_comb begin
      next_state   = state;
      next_tag     = tag;
      next_data    = data;
      next_ans     = drcm_pkg::ANS_NONE;
      next_rdata   = rdata;
      next_far_req = 1'h0;
      case (state)
         drcm_pkg::DRCM_FREE: begin
            if (RD_REQ) begin
               next_ans     = drcm_pkg::ANS_RETRY;
               next_tag     = req_tag;
               next_far_req = 1'h1;
               next_state   = drcm_pkg::DRCM_FETCH;
            end
         end
         drcm_pkg::DRCM_FETCH: begin
            if (RD_REQ) begin
               next_ans = drcm_pkg::ANS_RETRY;
            end
            if (FAR_RD_DONE) begin
               next_data  = FAR_RD_DATA;
               next_state = drcm_pkg::DRCM_HELD;
            end
         end
         drcm_pkg::DRCM_HELD: begin
            if (RD_REQ && hit) begin
               next_ans   = drcm_pkg::ANS_DATA;
               next_rdata = data;
               next_state = drcm_pkg::DRCM_FREE;
            end else if (RD_REQ) begin
               next_ans = drcm_pkg::ANS_RETRY;
            end
         end
         default: begin
            next_state = drcm_pkg::DRCM_FREE;
         end
      endcase
      // status flag registered so the pin comes from a flop
      next_held = (next_state == drcm_pkg::DRCM_HELD);
   end

   // delayed entry registers
   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         state   <= drcm_pkg::DRCM_FREE;
         tag     <= drcm_pkg::TAG_RST;
         data    <= drcm_pkg::DATA_RST;
         ans     <= drcm_pkg::ANS_NONE;
         rdata   <= drcm_pkg::DATA_RST;
         far_req <= 1'h0;
         held    <= 1'h0;
      end else begin
         state   <= next_state;
         tag     <= next_tag;
         data    <= next_data;
         ans     <= next_ans;
         rdata   <= next_rdata;
         far_req <= next_far_req;
         held    <= next_held;
      end
   end

   // posted write path, never touches held data
   always_comb begin
      next_wreq  = WR_REQ;
      next_waddr = WR_REQ ? WR_ADDR : waddr;
      next_wdata = WR_REQ ? WR_DATA : wdata;
      next_wbe   = WR_REQ ? WR_BE : wbe;
   end

   // posted write registers
   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         wreq  <= 1'h0;
         waddr <= '0;
         wdata <= drcm_pkg::DATA_RST;
         wbe   <= '0;
      end else begin
         wreq  <= next_wreq;
         waddr <= next_waddr;
         wdata <= next_wdata;
         wbe   <= next_wbe;
      end
   end

   // outputs straight from flip-flops
   assign RD_ANS      = ans;
   assign RD_DATA     = rdata;
   assign WR_ACK      = wreq;
   assign FAR_RD_REQ  = far_req;
   assign FAR_RD_ADDR = tag[drcm_pkg::TAG_W-1 -: drcm_pkg::ADDR_W];
   assign FAR_RD_CMD  = tag[drcm_pkg::BE_W +: drcm_pkg::CMD_W];
   assign FAR_RD_BE   = tag[drcm_pkg::BE_W-1:0];
   assign FAR_WR_REQ  = wreq;
   assign FAR_WR_ADDR = waddr;
   assign FAR_WR_DATA = wdata;
   assign FAR_WR_BE   = wbe;
   assign ENTRY_HELD  = held;

   // first read is retried and queued
   first_retry_a: assert property (@(posedge MCLK) disable iff (!RSTN)
      state == drcm_pkg::DRCM_FREE && RD_REQ |=>
      RD_ANS == drcm_pkg::ANS_RETRY && FAR_RD_REQ)
      else $error("first read not retried and queued");

   // data only for a matching read
   match_only_a: assert property (@(posedge MCLK) disable iff (!RSTN)
      RD_ANS == drcm_pkg::ANS_DATA |->
      $past(state) == drcm_pkg::DRCM_HELD && $past(hit))
      else $error("data given without full match");

   // matching retry gets held data
   held_deliver_a: assert property (@(posedge MCLK) disable iff (!RSTN)
      state == drcm_pkg::DRCM_HELD && RD_REQ && hit |=>
      RD_ANS == drcm_pkg::ANS_DATA && RD_DATA == $past(data))
      else $error("matching read not served");

   // fetched data captured and kept
   capture_keep_a: assert property (@(posedge MCLK) disable iff (!RSTN)
      state == drcm_pkg::DRCM_FETCH && FAR_RD_DONE |=>
      ENTRY_HELD && data == $past(FAR_RD_DATA))
      else $error("fetched data not held");

   // writes leave the held snapshot alone
   write_stale_a: assert property (@(posedge MCLK) disable iff (!RSTN)
      state == drcm_pkg::DRCM_HELD && WR_REQ && !RD_REQ |=>
      data == $past(data) && WR_ACK)
      else $error("held data changed by write");

   // delivery frees the entry
   free_after_a: assert property (@(posedge MCLK) disable iff (!RSTN)
      RD_ANS == drcm_pkg::ANS_DATA |-> state == drcm_pkg::DRCM_FREE)
      else $error("entry not freed after delivery");

   // same tag while fetching stays retried
   fetch_retry_a: assert property (@(posedge MCLK) disable iff (!RSTN)
      state == drcm_pkg::DRCM_FETCH && RD_REQ |=>
      RD_ANS == drcm_pkg::ANS_RETRY)
      else $error("read during fetch not retried");

   // mismatching read is retried
   miss_retry_a: assert property (@(posedge MCLK) disable iff (!RSTN)
      state == drcm_pkg::DRCM_HELD && RD_REQ && !hit |=>
      RD_ANS == drcm_pkg::ANS_RETRY && ENTRY_HELD)
      else $error("mismatch not retried");

   // main scenarios
   queue_c: cover property (@(posedge MCLK) disable iff (!RSTN)
      FAR_RD_REQ);
   write_held_c: cover property (@(posedge MCLK) disable iff (!RSTN)
      ENTRY_HELD && WR_REQ);
   deliver_c: cover property (@(posedge MCLK) disable iff (!RSTN)
      RD_ANS == drcm_pkg::ANS_DATA);
   busy_c: cover property (@(posedge MCLK) disable iff (!RSTN)
      state == drcm_pkg::DRCM_FETCH && RD_REQ);
endmodule

// >>> verif/drcm_far_model.sv
// far-side target model: answers fetches, absorbs posted writes
module drcm_far_model (
   // clock
   input  wire logic        clk,
   // fetch request and answer
   input  wire logic        rd_req,
   input  wire logic [31:0] rd_addr,
   output logic             rd_done,
   output logic [31:0]      rd_data,
   // posted write
   input  wire logic        wr_req,
   input  wire logic [31:0] wr_addr,
   input  wire logic [31:0] wr_data
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] mem [logic [31:0]];

   // absorb posted writes
   always @(posedge clk) begin
      if (wr_req) mem[wr_addr] = wr_data;
   end

   // answer a fetch after 1..8 cycles, data line scrambled otherwise
   initial begin
      rd_done = 1'h0;
      rd_data = 32'h0;
      forever begin
         @(posedge clk);
         if (rd_req) begin
            repeat ($urandom_range(8, 1)) @(negedge clk);
            rd_done <= 1'h1;
            rd_data <= mem.exists(rd_addr) ? mem[rd_addr]
                                           : rd_addr ^ 32'hA5A5_5A5A;
            @(negedge clk);
            rd_done <= 1'h0;
            rd_data <= ~rd_data;
         end
      end
   end
endmodule

// >>> verif/drcm_top_test.sv
// self-checking bench for the delayed read completion matcher
module drcm_top_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic MCLK, RSTN, RD_REQ, WR_REQ, WR_ACK, FAR_RD_REQ, FAR_RD_DONE;
   logic FAR_WR_REQ, ENTRY_HELD;
   logic [1:0]  RD_ANS;
   logic [3:0]  RD_CMD, RD_BE, WR_BE, FAR_RD_CMD, FAR_RD_BE, FAR_WR_BE;
   logic [31:0] RD_ADDR, WR_ADDR, WR_DATA, RD_DATA, FAR_RD_ADDR;
   logic [31:0] FAR_RD_DATA, FAR_WR_ADDR, FAR_WR_DATA, stale;
   logic [39:0] t;
   logic [31:0] shadow [logic [31:0]];
   int err_count = 0;
   int n_compared = 0;

   drcm_top uut (.MCLK, .RSTN, .RD_REQ, .RD_ADDR, .RD_CMD, .RD_BE, .WR_REQ,
      .WR_ADDR, .WR_DATA, .WR_BE, .RD_ANS, .RD_DATA, .WR_ACK, .FAR_RD_REQ,
      .FAR_RD_ADDR, .FAR_RD_CMD, .FAR_RD_BE, .FAR_RD_DONE, .FAR_RD_DATA,
      .FAR_WR_REQ, .FAR_WR_ADDR, .FAR_WR_DATA, .FAR_WR_BE, .ENTRY_HELD);
   drcm_far_model far (.clk(MCLK), .rd_req(FAR_RD_REQ),
      .rd_addr(FAR_RD_ADDR), .rd_done(FAR_RD_DONE), .rd_data(FAR_RD_DATA),
      .wr_req(FAR_WR_REQ), .wr_addr(FAR_WR_ADDR), .wr_data(FAR_WR_DATA));

   // clock
   initial begin
      MCLK = 1'h0;
      forever #5 MCLK = ~MCLK;
   end

   // far-side value of a location as the bench last wrote it
   function automatic logic [31:0] mem_val(logic [31:0] a);
      return shadow.exists(a) ? shadow[a] : a ^ 32'hA5A5_5A5A;
   endfunction

   task automatic check(string what, logic [65:0] seen, logic [65:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one read attempt; returns in the answer cycle
   task automatic rd(logic [39:0] tag);
      @(negedge MCLK);
      {RD_ADDR, RD_CMD, RD_BE} = tag;
      RD_REQ = 1'h1;
      @(negedge MCLK);
      RD_REQ = 1'h0;
      {RD_ADDR, RD_CMD, RD_BE} = ~tag;
   endtask

   // first attempt: retried, queued, then held once fetched
   task automatic fetch(logic [39:0] tag);
      int n;
      rd(tag);
      check("ans retry", RD_ANS, drcm_pkg::ANS_RETRY);
      check("far req", FAR_RD_REQ, 1'h1);
      check("far tag", {FAR_RD_ADDR, FAR_RD_CMD, FAR_RD_BE}, tag);
      // retry lands while still fetching, at the latest in the cycle the fetched data is captured
      rd(tag);
      check("busy retry", RD_ANS, drcm_pkg::ANS_RETRY);
      n = 0;
      while (ENTRY_HELD !== 1'h1 && n < 20) begin
         @(negedge MCLK);
         n++;
      end
      check("held", ENTRY_HELD, 1'h1);
   endtask

   // matching read takes the completion and frees the entry
   task automatic claim(logic [39:0] tag, logic [31:0] exp);
      rd(tag);
      check("ans data", RD_ANS, drcm_pkg::ANS_DATA);
      check("rd data", RD_DATA, exp);
      check("freed", ENTRY_HELD, 1'h0);
   endtask

   task automatic wr(logic [31:0] a, logic [31:0] d);
      @(negedge MCLK);
      {WR_REQ, WR_ADDR, WR_DATA, WR_BE} = {1'h1, a, d, 4'hF};
      @(negedge MCLK);
      WR_REQ = 1'h0;
      check("wr ack", WR_ACK, 1'h1);
      check("far wr", {FAR_WR_REQ, FAR_WR_ADDR}, {1'h1, a});
      check("far wr data", FAR_WR_DATA, d);
      check("far wr be", FAR_WR_BE, 4'hF);
      shadow[a] = d;
   endtask

   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // watchdog
   initial begin
      #200000;
      err_count++;
      complete_run();
   end

   // main sequence
   initial begin
      {RSTN, RD_REQ, WR_REQ, RD_ADDR, RD_CMD, RD_BE} = '0;
      {WR_ADDR, WR_DATA, WR_BE} = '0;
      void'($urandom(32'h6353));
      repeat (20) @(negedge MCLK);
      RSTN = 1'h1;
      // master A queues, near misses on each field are refused
      t = {32'h0000_1000, 4'h6, 4'hF};
      fetch(t);
      for (int i = 0; i < 3; i++) begin
         rd(t ^ (40'h1 << (i * 4)));
         check("miss", RD_ANS, drcm_pkg::ANS_RETRY);
      end
      check("still held", ENTRY_HELD, 1'h1);
      // master B writes then reads: gets the old snapshot
      stale = mem_val(32'h0000_1000);
      wr(32'h0000_1000, 32'h1234_5678);
      claim(t, stale);
      // entry freed: same read queues anew and sees the write
      fetch(t);
      claim(t, mem_val(32'h0000_1000));
      // random masters: exact start address, optional write first
      repeat (30) begin
         t = {$urandom() & 32'hFFFF_FFFC, 8'($urandom())};
         if ($urandom_range(1, 0) == 1) begin
            wr(t[39:8] ^ {29'h0, 1'($urandom()), 2'h0}, $urandom());
         end
         fetch(t);
         claim(t, mem_val(t[39:8]));
      end
      complete_run();
   end
endmodule
